/* core/exc_tail_pkg.sv */
// Constants shared by the translation-miss, breakpoint and management-interrupt exception logic
//------------------------------------------------------------------------------
// Overview of operation
// (RULE_01) Instruction fetch translation miss vectors 0x01000.
// (RULE_02) Data load translation miss vectors 0x01100.
// (RULE_03) Data store translation miss vectors 0x01200.
// (RULE_04) Store hit needing change bit vectors 0x01200.
// (RULE_05) Breakpoint address match on completing instruction: 0x01300.
// (RULE_06) Breakpoint only fires while enable bit set.
// (RULE_07) Management interrupt needs enable bit and input: 0x01400.
// (RULE_08) Signal only at completion; cancel younger instructions. The code also takes the management interrupt with no valid completion head.
// (RULE_09) Never dispatch into reserved vector ranges.
//------------------------------------------------------------------------------
package exc_tail_pkg;

    //--------------------------------------------------------------------------
    // Vector offsets
    //--------------------------------------------------------------------------
    localparam int          VEC_W         = 20;
    localparam logic [19:0] VEC_INSTRUCTION_TRANSLATION_BUFFER_MISS = 20'h01000;
    localparam logic [19:0] VEC_LOAD_MISS = 20'h01100;
    localparam logic [19:0] VEC_STORE_MISS = 20'h01200;
    localparam logic [19:0] VEC_BREAKPOINT = 20'h01300;
    localparam logic [19:0] VEC_MGMT_INT  = 20'h01400;
    localparam logic [19:0] RSV_A_LO      = 20'h00E10;
    localparam logic [19:0] RSV_A_HI      = 20'h00FFF;
    localparam logic [19:0] RSV_B_LO      = 20'h01500;
    localparam logic [19:0] RSV_B_HI      = 20'h02FFF;

    //--------------------------------------------------------------------------
    // Register map (byte addresses, one word each)
    //--------------------------------------------------------------------------
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  OFS_BREAKPT   = 4'h0;
    localparam logic [3:0]  OFS_STATUS    = 4'h4;
    localparam logic [3:0]  OFS_MASK      = 4'h8;
    localparam logic [3:0]  OFS_LAST_VEC  = 4'hC;

    // Breakpoint register fields, big-endian positions of bits 0-29, 30
    localparam int          BP_ADDR_LSB   = 2;
    localparam int          BP_EN_BIT     = 1;
    localparam logic [31:0] BP_RESET      = 32'h0000_0000;
    localparam logic [31:0] BP_WR_MASK    = 32'hFFFF_FFFE;

    // Event status layout
    localparam int          NUM_EVT       = 5;
    localparam int          EVT_INSTRUCTION_TRANSLATION_BUFFER      = 0;
    localparam int          EVT_LOAD      = 1;
    localparam int          EVT_STORE     = 2;
    localparam int          EVT_BREAKPT   = 3;
    localparam int          EVT_MGMT      = 4;
    localparam logic [4:0]  MASK_RESET    = 5'h00;

    // Cause selected for dispatch
    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_INSTRUCTION_TRANSLATION_BUFFER,
        CAUSE_BREAKPT,
        CAUSE_LOAD,
        CAUSE_STORE,
        CAUSE_MGMT
    } cause_t;

endpackage : exc_tail_pkg

/* core/exc_tail_unit.sv */
// Exception recognition for translation misses, breakpoint and management int
`timescale 1ns/1ps
module exc_tail_unit (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    // Head of the completion queue
    input  wire logic        head_valid_in,
    input  wire logic [31:0] head_addr_in,
    input  wire logic        head_instruction_translation_buffer_miss_in,
    input  wire logic        head_load_miss_in,
    input  wire logic        head_store_miss_in,
    input  wire logic        head_store_chg_in,
    // Machine state and external pin
    input  wire logic        external_interrupt_enable_bit_in,
    input  wire logic        system_management_interrupt_input_in,
    // Register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Dispatch to handler fetch
    output logic             exc_take_out,
    output logic      [19:0] exc_vector_out,
    output logic             cancel_younger_out,
    output logic             irq_out
);

    //--------------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------------
    logic [31:0]                        breakpt_ff;
    logic [exc_tail_pkg::NUM_EVT-1:0]   mask_ff;
    logic [19:0]                        last_vec_ff;
    logic                               take_ff;
    logic [19:0]                        vector_ff;
    logic                               cancel_ff;
    logic [31:0]                        rdata_ff;
    logic [exc_tail_pkg::NUM_EVT-1:0]   status_w;
    logic [exc_tail_pkg::NUM_EVT-1:0]   evt_set;
    logic [exc_tail_pkg::NUM_EVT-1:0]   evt_clr;
    logic                               bp_match;
    logic                               bp_hit;
    logic                               mgmt_req;
    exc_tail_pkg::cause_t               cause;
    logic [19:0]                        nxt_vector;
    logic [31:0]                        nxt_rdata;
    logic                               wr_bp;
    logic                               wr_status;
    logic                               wr_mask;

    assign wr_bp     = reg_wr_in && reg_addr_in == exc_tail_pkg::OFS_BREAKPT;
    assign wr_status = reg_wr_in && reg_addr_in == exc_tail_pkg::OFS_STATUS;
    assign wr_mask   = reg_wr_in && reg_addr_in == exc_tail_pkg::OFS_MASK;

    //--------------------------------------------------------------------------
    // Cause detection
    //--------------------------------------------------------------------------
    // Only the word address is compared; the low two bits are ignored
    assign bp_match = head_addr_in[31:exc_tail_pkg::BP_ADDR_LSB] ==
                      breakpt_ff[31:exc_tail_pkg::BP_ADDR_LSB]; // RULE_05
    assign bp_hit   = bp_match &&
                      breakpt_ff[exc_tail_pkg::BP_EN_BIT];     // RULE_06
    assign mgmt_req = external_interrupt_enable_bit_in &&
                      system_management_interrupt_input_in;     // RULE_07

    // Fetch miss first, since the instruction never really existed; the
    // pin interrupt is asynchronous and yields to any instruction fault
    always_comb begin
        cause = exc_tail_pkg::CAUSE_NONE;
        if (head_valid_in && head_instruction_translation_buffer_miss_in) begin           // RULE_08
            cause = exc_tail_pkg::CAUSE_INSTRUCTION_TRANSLATION_BUFFER;                   // RULE_01
        end else if (head_valid_in && bp_hit) begin
            cause = exc_tail_pkg::CAUSE_BREAKPT;                // RULE_05
        end else if (head_valid_in && head_load_miss_in) begin
            cause = exc_tail_pkg::CAUSE_LOAD;                   // RULE_02
        end else if (head_valid_in && (head_store_miss_in ||
                                       head_store_chg_in)) begin
            cause = exc_tail_pkg::CAUSE_STORE;                  // RULE_03 RULE_04
        end else if (mgmt_req) begin
            cause = exc_tail_pkg::CAUSE_MGMT;                   // RULE_07
        end
    end

    // Only the five named vectors can be produced; no reserved slot exists
    always_comb begin
        case (cause)
            exc_tail_pkg::CAUSE_INSTRUCTION_TRANSLATION_BUFFER:    nxt_vector = exc_tail_pkg::VEC_INSTRUCTION_TRANSLATION_BUFFER_MISS;
            exc_tail_pkg::CAUSE_BREAKPT: nxt_vector = exc_tail_pkg::VEC_BREAKPOINT;
            exc_tail_pkg::CAUSE_LOAD:    nxt_vector = exc_tail_pkg::VEC_LOAD_MISS;
            exc_tail_pkg::CAUSE_STORE:   nxt_vector = exc_tail_pkg::VEC_STORE_MISS;
            exc_tail_pkg::CAUSE_MGMT:    nxt_vector = exc_tail_pkg::VEC_MGMT_INT;
            default:                     nxt_vector = vector_ff; // RULE_09
        endcase
    end

    //--------------------------------------------------------------------------
    // Dispatch flops
    //--------------------------------------------------------------------------
    // Taking an exception flushes everything behind the completing slot
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            take_ff   <= 1'b0;
            cancel_ff <= 1'b0;
            vector_ff <= exc_tail_pkg::VEC_INSTRUCTION_TRANSLATION_BUFFER_MISS;
        end else if (ce_in) begin
            take_ff   <= cause != exc_tail_pkg::CAUSE_NONE;
            cancel_ff <= cause != exc_tail_pkg::CAUSE_NONE;     // RULE_08
            vector_ff <= nxt_vector;
        end
    end

    // Last vector dispatched, visible to software
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            last_vec_ff <= '0;
        end else if (ce_in && cause != exc_tail_pkg::CAUSE_NONE) begin
            last_vec_ff <= nxt_vector;
        end
    end

    //--------------------------------------------------------------------------
    // Registers
    //--------------------------------------------------------------------------
    // Bit 0 has no meaning and stays zero
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            breakpt_ff <= exc_tail_pkg::BP_RESET;
        end else if (ce_in && wr_bp) begin
            breakpt_ff <= reg_wdata_in & exc_tail_pkg::BP_WR_MASK;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mask_ff <= exc_tail_pkg::MASK_RESET;
        end else if (ce_in && wr_mask) begin
            mask_ff <= reg_wdata_in[exc_tail_pkg::NUM_EVT-1:0];
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        nxt_rdata = '0;
        case (reg_addr_in)
            exc_tail_pkg::OFS_BREAKPT:  nxt_rdata = breakpt_ff;
            exc_tail_pkg::OFS_STATUS:   nxt_rdata[exc_tail_pkg::NUM_EVT-1:0]
                                            = status_w;
            exc_tail_pkg::OFS_MASK:     nxt_rdata[exc_tail_pkg::NUM_EVT-1:0]
                                            = mask_ff;
            exc_tail_pkg::OFS_LAST_VEC: nxt_rdata[19:0] = last_vec_ff;
            default:                    nxt_rdata = '0;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_ff <= '0;
        end else if (ce_in) begin
            rdata_ff <= reg_rd_in ? nxt_rdata : 32'h0000_0000;
        end
    end

    //--------------------------------------------------------------------------
    // Event status and interrupt
    //--------------------------------------------------------------------------
    always_comb begin
        evt_set = '0;
        evt_set[exc_tail_pkg::EVT_INSTRUCTION_TRANSLATION_BUFFER]    = cause == exc_tail_pkg::CAUSE_INSTRUCTION_TRANSLATION_BUFFER;
        evt_set[exc_tail_pkg::EVT_LOAD]    = cause == exc_tail_pkg::CAUSE_LOAD;
        evt_set[exc_tail_pkg::EVT_STORE]   = cause == exc_tail_pkg::CAUSE_STORE;
        evt_set[exc_tail_pkg::EVT_BREAKPT] =
            cause == exc_tail_pkg::CAUSE_BREAKPT;
        evt_set[exc_tail_pkg::EVT_MGMT]    = cause == exc_tail_pkg::CAUSE_MGMT;
    end

    assign evt_clr = wr_status ? reg_wdata_in[exc_tail_pkg::NUM_EVT-1:0] : '0;

    sticky_flags #(
        .WIDTH (exc_tail_pkg::NUM_EVT)
    ) u_flags (
        .clk_in    (clk_in),
        .srst_in   (srst_in),
        .ce_in     (ce_in),
        .set_in    (evt_set),
        .clr_in    (evt_clr),
        .mask_in   (mask_ff),
        .flags_out (status_w),
        .irq_out   (irq_out)
    );

    assign exc_take_out       = take_ff;
    assign exc_vector_out     = vector_ff;
    assign cancel_younger_out = cancel_ff;
    assign reg_rdata_out      = rdata_ff;

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------
    chk_instruction_translation_buffer_vector: assert property ( // RULE_01
        @(posedge clk_in) disable iff (srst_in)
        ce_in && head_valid_in && head_instruction_translation_buffer_miss_in |=>
            exc_take_out && exc_vector_out == exc_tail_pkg::VEC_INSTRUCTION_TRANSLATION_BUFFER_MISS)
        else $error("fetch miss did not vector to 0x01000");

    chk_load_vector: assert property ( // RULE_02
        @(posedge clk_in) disable iff (srst_in)
        ce_in && head_valid_in && !head_instruction_translation_buffer_miss_in && !bp_hit &&
        head_load_miss_in |=>
            exc_take_out && exc_vector_out == exc_tail_pkg::VEC_LOAD_MISS)
        else $error("load miss did not vector to 0x01100");

    chk_store_miss: assert property ( // RULE_03
        @(posedge clk_in) disable iff (srst_in)
        ce_in && head_valid_in && !head_instruction_translation_buffer_miss_in && !bp_hit &&
        !head_load_miss_in && head_store_miss_in |=>
            exc_vector_out == exc_tail_pkg::VEC_STORE_MISS)
        else $error("store miss did not vector to 0x01200");

    chk_store_change: assert property ( // RULE_04
        @(posedge clk_in) disable iff (srst_in)
        ce_in && head_valid_in && !head_instruction_translation_buffer_miss_in && !bp_hit &&
        !head_load_miss_in && head_store_chg_in |=>
            exc_take_out && exc_vector_out == exc_tail_pkg::VEC_STORE_MISS)
        else $error("change-bit store did not vector to 0x01200");

    chk_bp_vector: assert property ( // RULE_05
        @(posedge clk_in) disable iff (srst_in)
        ce_in && head_valid_in && !head_instruction_translation_buffer_miss_in &&
        head_addr_in[31:2] == breakpt_ff[31:2] && breakpt_ff[1] |=>
            exc_vector_out == exc_tail_pkg::VEC_BREAKPOINT)
        else $error("breakpoint match did not vector to 0x01300");

    chk_bp_disabled: assert property ( // RULE_06
        @(posedge clk_in) disable iff (srst_in)
        ce_in && head_valid_in && !breakpt_ff[1] && !head_instruction_translation_buffer_miss_in &&
        !head_load_miss_in && !head_store_miss_in && !head_store_chg_in &&
        !(external_interrupt_enable_bit_in &&
          system_management_interrupt_input_in) |=> !exc_take_out)
        else $error("breakpoint fired while disabled");

    chk_mgmt_gate: assert property ( // RULE_07
        @(posedge clk_in) disable iff (srst_in)
        ce_in && !head_valid_in && !external_interrupt_enable_bit_in |=>
            !exc_take_out)
        else $error("management interrupt taken with enable clear");

    chk_mgmt_vector: assert property ( // RULE_07
        @(posedge clk_in) disable iff (srst_in)
        ce_in && !head_valid_in && external_interrupt_enable_bit_in &&
        system_management_interrupt_input_in |=>
            exc_take_out && exc_vector_out == exc_tail_pkg::VEC_MGMT_INT)
        else $error("management interrupt did not vector to 0x01400");

    chk_cancel_pair: assert property ( // RULE_08
        @(posedge clk_in) disable iff (srst_in)
        exc_take_out == cancel_younger_out)
        else $error("take and cancel disagree");

    chk_reserved_vec: assert property ( // RULE_09
        @(posedge clk_in) disable iff (srst_in)
        exc_take_out |-> !(exc_vector_out >= exc_tail_pkg::RSV_A_LO &&
                           exc_vector_out <= exc_tail_pkg::RSV_A_HI) &&
                         !(exc_vector_out >= exc_tail_pkg::RSV_B_LO &&
                           exc_vector_out <= exc_tail_pkg::RSV_B_HI))
        else $error("dispatch into a reserved vector range");

    chk_instruction_translation_buffer_status: assert property ( // RULE_01
        @(posedge clk_in) disable iff (srst_in)
        ce_in && head_valid_in && head_instruction_translation_buffer_miss_in |=>
            status_w[exc_tail_pkg::EVT_INSTRUCTION_TRANSLATION_BUFFER])
        else $error("fetch miss did not set its status bit");

    chk_bp_status: assert property ( // RULE_05
        @(posedge clk_in) disable iff (srst_in)
        ce_in && head_valid_in && !head_instruction_translation_buffer_miss_in &&
        head_addr_in[31:2] == breakpt_ff[31:2] && breakpt_ff[1] |=>
            status_w[exc_tail_pkg::EVT_BREAKPT])
        else $error("breakpoint match did not set its status bit");

    chk_mgmt_status: assert property ( // RULE_07
        @(posedge clk_in) disable iff (srst_in)
        ce_in && !head_valid_in && external_interrupt_enable_bit_in &&
        system_management_interrupt_input_in |=>
            status_w[exc_tail_pkg::EVT_MGMT])
        else $error("management interrupt did not set its status bit");

    chk_quiet_head: assert property ( // RULE_08
        @(posedge clk_in) disable iff (srst_in)
        ce_in && !head_valid_in && !system_management_interrupt_input_in |=>
            !exc_take_out && !cancel_younger_out)
        else $error("exception signalled with no completing instruction");

    chk_ce_freeze: assert property ( // RULE_08
        @(posedge clk_in) disable iff (srst_in)
        !ce_in |=> $stable(exc_take_out) && $stable(exc_vector_out))
        else $error("dispatch outputs moved while clock enable low");

    chk_last_vec: assert property ( // RULE_09
        @(posedge clk_in) disable iff (srst_in)
        exc_take_out |-> last_vec_ff == exc_vector_out)
        else $error("last vector register disagrees with dispatch");

endmodule : exc_tail_unit

/* core/sticky_flags.sv */
// Sticky event flags with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps
module sticky_flags #(
    parameter int WIDTH = 5
) (
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic [WIDTH-1:0] clr_in,
    input  wire logic [WIDTH-1:0] mask_in,
    output logic      [WIDTH-1:0] flags_out,
    output logic                  irq_out
);

    logic [WIDTH-1:0] nxt_flags;

    // Set wins over a clear landing in the same cycle
    always_comb begin
        nxt_flags = (flags_out & ~clr_in) | set_in;
    end

    //--------------------------------------------------------------------------
    // Flag and interrupt flops
    //--------------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flags_out <= '0;
            irq_out   <= 1'b0;
        end else if (ce_in) begin
            flags_out <= nxt_flags;
            irq_out   <= |(nxt_flags & mask_in); // Level, from a flop
        end
    end

endmodule : sticky_flags

/* dv/exc_tail_unit_tb.sv */
// Self-checking bench for the tail exception recognition unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_errors++; $display("wrong value %s exp %h seen %h", nm, e, g); end end
module exc_tail_unit_tb;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        ce_in = 1'b1;
    logic        hv = 1'b0, hi = 1'b0, hl = 1'b0, hs = 1'b0, hc = 1'b0;
    logic [31:0] haddr = 32'h0, reg_wdata = 32'h0, rdata;
    logic [31:0] bp_exp = 32'h0;
    logic        ee = 1'b0, raise = 1'b0, slow = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic        take, cancel, irq, pin;
    logic [19:0] vec;
    int          n_errors = 0, checks_done = 0, cyc = 0;
    int          bits[6] = '{exc_tail_pkg::EVT_INSTRUCTION_TRANSLATION_BUFFER,
        exc_tail_pkg::EVT_LOAD, exc_tail_pkg::EVT_STORE,
        exc_tail_pkg::EVT_BREAKPT, exc_tail_pkg::EVT_MGMT,
        exc_tail_pkg::EVT_STORE};
    logic [19:0] vecs[6] = '{exc_tail_pkg::VEC_INSTRUCTION_TRANSLATION_BUFFER_MISS,
        exc_tail_pkg::VEC_LOAD_MISS, exc_tail_pkg::VEC_STORE_MISS,
        exc_tail_pkg::VEC_BREAKPOINT, exc_tail_pkg::VEC_MGMT_INT,
        exc_tail_pkg::VEC_STORE_MISS};

    always #10 clk_in = ~clk_in;

    exc_tail_unit dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
        .head_valid_in(hv), .head_addr_in(haddr), .head_instruction_translation_buffer_miss_in(hi),
        .head_load_miss_in(hl), .head_store_miss_in(hs),
        .head_store_chg_in(hc), .external_interrupt_enable_bit_in(ee),
        .system_management_interrupt_input_in(pin), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata), .exc_take_out(take), .exc_vector_out(vec),
        .cancel_younger_out(cancel), .irq_out(irq));

    mgmt_pin_model far (.clk_in(clk_in), .srst_in(srst_in),
        .raise_in(raise), .slow_in(slow), .pin_out(pin));

    //--------------------------------------------------------------------
    // Expectation, drivers and checks
    //--------------------------------------------------------------------
    // Priority ladder; instruction causes need a valid completion head
    function automatic logic [20:0] exp_out();
        logic hit;
        hit = bp_exp[1] && (bp_exp[31:2] == haddr[31:2]);
        if (hv && hi) return {1'b1, exc_tail_pkg::VEC_INSTRUCTION_TRANSLATION_BUFFER_MISS};
        if (hv && hit) return {1'b1, exc_tail_pkg::VEC_BREAKPOINT};
        if (hv && hl) return {1'b1, exc_tail_pkg::VEC_LOAD_MISS};
        if (hv && (hs || hc)) return {1'b1, exc_tail_pkg::VEC_STORE_MISS};
        if (ee && pin) return {1'b1, exc_tail_pkg::VEC_MGMT_INT};
        return 21'h0;
    endfunction : exp_out

    // Called just after an edge at which the head inputs were driven
    task automatic step();
        logic [20:0] e;
        logic        rsv;
        @(negedge clk_in);
        e = exp_out();
        @(posedge clk_in);
        #1;
        `CHK("take", e[20], take)
        `CHK("cancel", e[20], cancel)
        if (e[20]) `CHK("vector", e[19:0], vec)
        rsv = (vec >= exc_tail_pkg::RSV_A_LO && vec <= exc_tail_pkg::RSV_A_HI)
           || (vec >= exc_tail_pkg::RSV_B_LO && vec <= exc_tail_pkg::RSV_B_HI);
        `CHK("reserved", 1'b0, rsv)
    endtask : step

    task automatic idle();
        hv <= 1'b0;
        hi <= 1'b0;
        hl <= 1'b0;
        hs <= 1'b0;
        hc <= 1'b0;
        ee <= 1'b0;
        raise <= 1'b0;
    endtask : idle

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        #1;
        `CHK("read data", e, rdata)
    endtask : reg_read

    task automatic end_sim();
        $display("checks_done %0d n_errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // Hang guard: the sequence needs a few thousand cycles at most
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            end_sim();
        end
    end

    //--------------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------------
    initial begin
        void'($urandom(91));
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        #1;
        `CHK("reset vector", exc_tail_pkg::VEC_INSTRUCTION_TRANSLATION_BUFFER_MISS, vec)
        `CHK("reset take", 1'b0, take)
        for (int a = 0; a < 16; a += 4) reg_read(4'(a), 32'h0);
        reg_write(4'h1, 32'hFFFF_FFFF);
        reg_write(exc_tail_pkg::OFS_LAST_VEC, 32'hFFFF_FFFF);
        reg_read(4'h1, 32'h0);
        reg_read(exc_tail_pkg::OFS_LAST_VEC, 32'h0);
        reg_write(exc_tail_pkg::OFS_BREAKPT, 32'hFFFF_FFFF);
        reg_read(exc_tail_pkg::OFS_BREAKPT, 32'hFFFF_FFFE);
        bp_exp = 32'h0000_4A12;
        reg_write(exc_tail_pkg::OFS_BREAKPT, bp_exp);
        // Each cause alone: vector, sticky status, mask, clear
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_in);
            hv <= (k != 4);
            hi <= (k == 0);
            hl <= (k == 1);
            hs <= (k == 2);
            hc <= (k == 5);
            haddr <= (k == 3) ? 32'h0000_4A13 : 32'h0000_8000;
            ee <= (k == 4);
            raise <= (k == 4);
            if (k == 4) repeat (2) @(posedge clk_in);
            step();
            @(posedge clk_in);
            idle();
            repeat (3) @(posedge clk_in);
            reg_read(exc_tail_pkg::OFS_STATUS, 32'(1 << bits[k]));
            reg_read(exc_tail_pkg::OFS_LAST_VEC, 32'(vecs[k]));
            `CHK("irq masked", 1'b0, irq)
            reg_write(exc_tail_pkg::OFS_MASK, 32'(1 << bits[k]));
            repeat (2) @(posedge clk_in);
            #1;
            `CHK("irq", 1'b1, irq)
            reg_write(exc_tail_pkg::OFS_STATUS, 32'(1 << bits[k]));
            repeat (2) @(posedge clk_in);
            #1;
            `CHK("irq cleared", 1'b0, irq)
            reg_read(exc_tail_pkg::OFS_STATUS, 32'h0);
            reg_write(exc_tail_pkg::OFS_MASK, 32'h0);
        end
        // Refusals: no valid head, pin without enable, breakpoint disabled
        @(posedge clk_in);
        {hi, hl, hs, hc, raise} <= 5'h1F;
        repeat (2) @(posedge clk_in);
        step();
        reg_write(exc_tail_pkg::OFS_BREAKPT, 32'h0000_4A10);
        bp_exp = 32'h0000_4A10;
        @(posedge clk_in);
        {hi, hl, hs, hc, raise} <= 5'h00;
        hv <= 1'b1;
        haddr <= 32'h0000_4A10;
        step();
        reg_write(exc_tail_pkg::OFS_BREAKPT, 32'h0000_4A12);
        bp_exp = 32'h0000_4A12;
        // Priority: peel causes off one by one
        @(posedge clk_in);
        {hv, hi, hl, hs, ee, raise} <= 6'h3F;
        repeat (2) @(posedge clk_in);
        step();
        @(posedge clk_in);
        hi <= 1'b0;
        step();
        @(posedge clk_in);
        haddr <= 32'h0000_0100;
        step();
        @(posedge clk_in);
        hl <= 1'b0;
        step();
        @(posedge clk_in);
        hs <= 1'b0;
        step();
        // Clock enable low freezes the unit
        @(posedge clk_in);
        idle();
        repeat (2) @(posedge clk_in);
        ce_in <= 1'b0;
        hv <= 1'b1;
        hi <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        `CHK("frozen take", 1'b0, take)
        @(posedge clk_in);
        ce_in <= 1'b1;
        idle();
        // Random traffic, addresses often near the breakpoint
        for (int n = 0; n < 400; n++) begin
            @(posedge clk_in);
            hv <= 1'($urandom);
            hi <= ($urandom % 6 == 0);
            hl <= ($urandom % 4 == 0);
            hs <= ($urandom % 4 == 0);
            hc <= ($urandom % 5 == 0);
            ee <= 1'($urandom);
            raise <= 1'($urandom);
            slow <= ($urandom % 8 == 0);
            haddr <= ($urandom % 2) ? {bp_exp[31:2], 2'($urandom)} : $urandom;
            step();
        end
        end_sim();
    end
endmodule : exc_tail_unit_tb

/* dv/mgmt_pin_model.sv */
// Behavioural model of the system logic driving the management interrupt
`timescale 1ns/1ps
module mgmt_pin_model (
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic raise_in,
    input  wire logic slow_in,
    output logic      pin_out
);
    logic [2:0] dly_ff;

    //--------------------------------------------------------------------
    // Delay line
    //--------------------------------------------------------------------
    // Pin only changes at rising edges so the bench can sample it safely
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            dly_ff <= 3'h0;
        end else begin
            dly_ff <= {dly_ff[1:0], raise_in};
        end
    end

    // Slow mode answers two cycles later than prompt mode
    assign pin_out = slow_in ? dly_ff[2] : dly_ff[0];
endmodule : mgmt_pin_model
